//--- design/irr_pkg.sv
// constants, field layouts and carrier types of the remote receiver status
// Functional notes
// R1 - status bit 15 flags leader interrupt
// R2 - status bit 14 flags excess low width
// R3 - status bit 13 flags maximum bit cycle
// R4 - status bit 12 flags data falling edge
// R5 - status bit 7 shows leader seen
// R6 - 7-bit count: 0 leader, 1..72, 73+
// R7 - count loaded only when reception completes
// R8 - whole status refreshed on every interrupt; the code keeps the old count except on completion
// R9 - software writes to status are ignored
// R10 - keep receiving beyond 72 bits until completion
// R11 - end counts: 7-bit, 0 none, 1..72
// R12 - software never programs end counts above 72
// R13 - three independent end-count settings
// R14 - end counts act only with maximum cycle
// R15 - nonzero end counts gate completion on match
// R16 - no edge within limit completes reception
// R17 - falling edge interrupt on each data edge
// R18 - newer frame result overwrites older one
// R19 - flags show only the current interrupt cause
package irr_pkg;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFS_RX_STATUS  = 8'h00;
    localparam logic [7:0] OFS_END_A      = 8'h04;
    localparam logic [7:0] OFS_END_B      = 8'h08;
    localparam logic [7:0] OFS_END_C      = 8'h0c;
    localparam logic [7:0] OFS_CONTROL    = 8'h10;
    localparam logic [7:0] OFS_MAX_CYCLE  = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h1c;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BIT_LEADER_IF   = 15;
    localparam int BIT_LOW_IF      = 14;
    localparam int BIT_MAX_IF      = 13;
    localparam int BIT_EDGE_IF     = 12;
    localparam int BIT_LEADER_SEEN = 7;
    localparam int CNT_W           = 7;
    localparam int CTL_ENABLE      = 0;
    localparam int CTL_LEADER_IEN  = 1;
    localparam int CTL_LOW_IEN     = 2;
    localparam int CTL_EDGE_IEN    = 3;
    localparam int EVT_W           = 4;

    // ****************************************************************
    // reset values and limits
    // ****************************************************************
    localparam logic [CNT_W-1:0] END_COUNT_RESET = 7'h00;
    localparam logic [CNT_W-1:0] COUNT_MAX_EXACT = 7'h48;
    localparam logic [CNT_W-1:0] COUNT_SAT       = 7'h7f;
    localparam logic [3:0]       CONTROL_RESET   = 4'h0;
    localparam logic [7:0]       MAX_CYCLE_RESET = 8'h00;
    localparam logic [3:0]       IRQ_MASK_RESET  = 4'h0;

    // ****************************************************************
    // timing: sampling clock derived from the system clock
    // ****************************************************************
    localparam int CLK_PERIOD_PS    = 4000;
    localparam int SAMPLE_PERIOD_PS = 30518000;
    localparam int SAMPLE_DIV       = SAMPLE_PERIOD_PS / CLK_PERIOD_PS;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic             leader_irq_flag;
        logic             low_width_irq_flag;
        logic             max_cycle_irq_flag;
        logic             falling_edge_irq_flag;
        logic             leader_seen;
        logic [CNT_W-1:0] received_bit_count;
    } irr_status_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RECEIVE
    } irr_state_e;

endpackage : irr_pkg

//--- design/irr_status_end_count.sv
// remote receiver status, end-bit-count logic and wishbone register slave
`timescale 1ns/1ps
module irr_status_end_count
    import irr_pkg::*;
#(
    parameter int P_SAMPLE_DIV = SAMPLE_DIV
) (
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    // wishbone classic slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // demodulated remote signal and front-end events
    input  wire logic        i_remote_in,
    input  wire logic        i_leader_detect,
    input  wire logic        i_low_width_detect,
    // frame results
    output logic             o_rx_complete,
    output logic             o_irq
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [15:0]      div_reg;
    logic             tick;
    logic             wb_req;
    logic             wb_wr;
    logic             ack_reg;
    logic [31:0]      rdata_reg;
    logic [31:0]      rdata_next;

    logic [CNT_W-1:0] end_a_reg;
    logic [CNT_W-1:0] end_b_reg;
    logic [CNT_W-1:0] end_c_reg;
    logic [3:0]       control_reg;
    logic [7:0]       max_cycle_reg;
    logic [3:0]       irq_status_reg;
    logic [3:0]       irq_mask_reg;
    irr_status_s      status_reg;
    irr_status_s      status_next;

    irr_state_e       state_reg;
    logic             sample_reg;
    logic [7:0]       cycle_reg;
    logic [CNT_W-1:0] count_reg;
    logic             leader_seen_reg;
    logic             complete_reg;

    logic             enabled;
    logic             fall;
    logic             ev_leader;
    logic             ev_edge;
    logic             ev_low;
    logic             max_hit;
    logic             end_ok;
    logic             ev_max;
    logic [CNT_W-1:0] count_now;
    logic [3:0]       ev_vec;
    logic             any_ev;
    logic             wr_end_a;
    logic             wr_end_b;
    logic             wr_end_c;
    logic             wr_control;
    logic             wr_max_cycle;
    logic             wr_irq_mask;
    logic             wr_irq_clear;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // byte-lane write merge of a narrow field held in the low byte
    function automatic logic [CNT_W-1:0] merge_end(
        input logic [CNT_W-1:0] old_val,
        input logic [31:0]      wdat,
        input logic [3:0]       sel
    );
        merge_end = sel[0] ? wdat[CNT_W-1:0] : old_val;
    endfunction : merge_end

    // a zero setting never matches, so it means no specific count
    function automatic logic end_match(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] setting
    );
        end_match = (setting != END_COUNT_RESET) && (cnt == setting);
    endfunction : end_match

    // one register chosen by a bus write; byte lanes are checked apart
    function automatic logic wr_hit(
        input logic       wr,
        input logic [7:0] adr,
        input logic [7:0] ofs
    );
        wr_hit = wr && (adr == ofs);
    endfunction : wr_hit

    // ****************************************************************
    // sampling-clock divider
    // ****************************************************************
    // edge sampling and cycle counting move only on this enable; leader and low-width detects act on any clock
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            div_reg <= 16'h0000;
        end else if (div_reg == 16'(P_SAMPLE_DIV - 1)) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    assign tick = (div_reg == 16'(P_SAMPLE_DIV - 1));

    // ****************************************************************
    // event detection
    // ****************************************************************
    assign enabled   = control_reg[CTL_ENABLE];
    assign fall      = tick && sample_reg && !i_remote_in;
    assign max_hit   = tick && (max_cycle_reg != MAX_CYCLE_RESET)
                       && (cycle_reg + 8'h01 >= max_cycle_reg);

    // a falling edge ends a data bit; count saturates to keep 73+ code
    assign count_now = (count_reg == COUNT_SAT) ? count_reg
                       : count_reg + 7'h01; // R10

    // leader restarts a frame even mid-reception
    assign ev_leader = enabled && i_leader_detect;
    assign ev_low    = enabled && !ev_leader && (state_reg == ST_RECEIVE)
                       && i_low_width_detect;
    assign ev_edge   = enabled && !ev_leader && !ev_low
                       && (state_reg == ST_RECEIVE) && fall;

    // end counts only qualify a maximum-cycle completion
    assign end_ok = ((end_a_reg == END_COUNT_RESET)
                     && (end_b_reg == END_COUNT_RESET)
                     && (end_c_reg == END_COUNT_RESET))
                    || end_match(count_reg, end_a_reg)
                    || end_match(count_reg, end_b_reg)
                    || end_match(count_reg, end_c_reg); // R13 R15
    assign ev_max = enabled && !ev_leader && !ev_low && !fall
                    && (state_reg == ST_RECEIVE) && max_hit; // R14 R16

    // ****************************************************************
    // reception sequencing
    // ****************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            sample_reg <= 1'b1;
        end else if (tick) begin
            sample_reg <= i_remote_in;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state_reg       <= ST_IDLE;
            cycle_reg       <= 8'h00;
            count_reg       <= END_COUNT_RESET;
            leader_seen_reg <= 1'b0;
        end else if (!enabled) begin
            state_reg       <= ST_IDLE;
            cycle_reg       <= 8'h00;
            count_reg       <= END_COUNT_RESET;
            leader_seen_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (ev_leader) begin
                        state_reg       <= ST_RECEIVE;
                        cycle_reg       <= 8'h00;
                        count_reg       <= END_COUNT_RESET;
                        leader_seen_reg <= 1'b1;
                    end
                end
                ST_RECEIVE: begin
                    if (ev_leader) begin
                        cycle_reg       <= 8'h00;
                        count_reg       <= END_COUNT_RESET;
                        leader_seen_reg <= 1'b1;
                    end else if (ev_low) begin
                        state_reg       <= ST_IDLE;
                        leader_seen_reg <= 1'b0;
                    end else if (fall) begin
                        cycle_reg <= 8'h00;
                        count_reg <= count_now; // R10
                    end else if (max_hit) begin
                        // maximum cycle ends the frame, completed if all end counts are zero or the length matches one, else dropped; wait for leader
                        state_reg       <= ST_IDLE;
                        leader_seen_reg <= 1'b0; // R15
                    end else if (tick) begin
                        cycle_reg <= cycle_reg + 8'h01;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // receive status refresh
    // ****************************************************************
    always_comb begin
        ev_vec    = 4'h0;
        ev_vec[3] = ev_leader && control_reg[CTL_LEADER_IEN]; // R1
        ev_vec[2] = ev_low; // R2
        ev_vec[1] = ev_max && end_ok; // R3 R15
        ev_vec[0] = ev_edge && control_reg[CTL_EDGE_IEN]; // R4 R17
        any_ev    = |ev_vec;
    end

    always_comb begin
        status_next                       = status_reg;
        status_next.leader_irq_flag       = ev_vec[3]; // R19
        status_next.low_width_irq_flag    = ev_vec[2];
        status_next.max_cycle_irq_flag    = ev_vec[1];
        status_next.falling_edge_irq_flag = ev_vec[0];
        status_next.leader_seen           = ev_leader
                                            || leader_seen_reg; // R5
        if (ev_vec[2] || ev_vec[1]) begin
            status_next.received_bit_count = count_reg; // R6 R7 R18
        end
    end

    // refreshed only when an interrupt is raised; bus writes never land
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            status_reg <= '0;
        end else if (any_ev) begin
            status_reg <= status_next; // R8 R9
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            complete_reg <= 1'b0;
        end else begin
            complete_reg <= ev_low || (ev_max && end_ok);
        end
    end

    assign o_rx_complete = complete_reg;

    // ****************************************************************
    // interrupt status, mask and output
    // ****************************************************************
    // a new event in the clearing cycle survives the clear
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            irq_status_reg <= 4'h0;
        end else if (wr_irq_clear) begin
            irq_status_reg <= (irq_status_reg & ~i_wb_dat[15:12]) | ev_vec;
        end else begin
            irq_status_reg <= irq_status_reg | ev_vec;
        end
    end

    assign o_irq = |(irq_status_reg & irq_mask_reg);

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    // one wait state: ack rises the cycle after the request, then drops
    assign wb_req = i_wb_cyc && i_wb_stb && !ack_reg;
    assign wb_wr  = wb_req && i_wb_we;

    // writes to the status register or unmapped offsets hit nothing
    assign wr_end_a     = wr_hit(wb_wr, i_wb_adr, OFS_END_A);
    assign wr_end_b     = wr_hit(wb_wr, i_wb_adr, OFS_END_B);
    assign wr_end_c     = wr_hit(wb_wr, i_wb_adr, OFS_END_C);
    assign wr_control   = wr_hit(wb_wr, i_wb_adr, OFS_CONTROL)
                          && i_wb_sel[0];
    assign wr_max_cycle = wr_hit(wb_wr, i_wb_adr, OFS_MAX_CYCLE)
                          && i_wb_sel[0];
    assign wr_irq_mask  = wr_hit(wb_wr, i_wb_adr, OFS_IRQ_MASK)
                          && i_wb_sel[1];
    assign wr_irq_clear = wr_hit(wb_wr, i_wb_adr, OFS_IRQ_STATUS)
                          && i_wb_sel[1];

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_req;
        end
    end

    // each end count is its own register; the three never interact
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            end_a_reg <= END_COUNT_RESET;
        end else if (wr_end_a) begin
            end_a_reg <= merge_end(end_a_reg, i_wb_dat, i_wb_sel); // R11
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            end_b_reg <= END_COUNT_RESET;
        end else if (wr_end_b) begin
            end_b_reg <= merge_end(end_b_reg, i_wb_dat, i_wb_sel); // R13
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            end_c_reg <= END_COUNT_RESET;
        end else if (wr_end_c) begin
            end_c_reg <= merge_end(end_c_reg, i_wb_dat, i_wb_sel); // R13
        end
    end

    // clearing enable drops a frame in progress; settings are kept
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            control_reg <= CONTROL_RESET;
        end else if (wr_control) begin
            control_reg <= i_wb_dat[3:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            max_cycle_reg <= MAX_CYCLE_RESET;
        end else if (wr_max_cycle) begin
            max_cycle_reg <= i_wb_dat[7:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            irq_mask_reg <= IRQ_MASK_RESET;
        end else if (wr_irq_mask) begin
            irq_mask_reg <= i_wb_dat[15:12];
        end
    end

    // reserved bits and unmapped offsets read as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (i_wb_adr)
            OFS_RX_STATUS:  rdata_next[15:0] = {status_reg[11:8], 4'h0,
                                                status_reg[7:0]};
            OFS_END_A:      rdata_next[CNT_W-1:0] = end_a_reg;
            OFS_END_B:      rdata_next[CNT_W-1:0] = end_b_reg;
            OFS_END_C:      rdata_next[CNT_W-1:0] = end_c_reg;
            OFS_CONTROL:    rdata_next[3:0] = control_reg;
            OFS_MAX_CYCLE:  rdata_next[7:0] = max_cycle_reg;
            OFS_IRQ_STATUS: rdata_next[15:12] = irq_status_reg;
            OFS_IRQ_MASK:   rdata_next[15:12] = irq_mask_reg;
            default:        rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rdata_reg <= 32'h0000_0000;
        end else if (wb_req && !i_wb_we) begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_wb_dat = rdata_reg;
    assign o_wb_ack = ack_reg;

endmodule : irr_status_end_count

//--- tb/irr_remote_model.sv
// behavioural remote front end: demodulated line and detector pulses
`timescale 1ns/1ps
module irr_remote_model #(
    parameter int P_HALF = 8
) (
    input  wire logic i_mclk,
    output logic      o_remote,
    output logic      o_leader,
    output logic      o_low_width
);
    // line idles high; each level lasts two sample ticks so none is missed
    initial begin
        o_remote    = 1'b1;
        o_leader    = 1'b0;
        o_low_width = 1'b0;
    end
    task automatic pulse(input bit is_leader);
        @(posedge i_mclk);
        if (is_leader) o_leader <= 1'b1;
        else o_low_width <= 1'b1;
        @(posedge i_mclk);
        o_leader    <= 1'b0;
        o_low_width <= 1'b0;
    endtask : pulse
    task automatic send_bits(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (P_HALF) @(posedge i_mclk);
            o_remote <= 1'b0;
            repeat (P_HALF) @(posedge i_mclk);
            o_remote <= 1'b1;
        end
    endtask : send_bits
endmodule : irr_remote_model

//--- tb/irr_status_end_count_tb_top.sv
// self-checking bench of the remote receiver status and end-count block
`timescale 1ns/1ps
module irr_status_end_count_tb_top
    import irr_pkg::*;
;
    logic        i_mclk, i_reset, cyc, stb, we, ack, remote, leader;
    logic        low_w, done, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] lfsr_q = 16'h6915;
    int          error_cnt = 0, checks = 0, done_cnt = 0, cycles = 0;
    int          last, n;
    const int    ns[6] = '{4, 3, 6, 5, 9, 2};
    const logic [7:0] addrs[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
                                   8'h14, 8'h18, 8'h1c, 8'h40};

    irr_status_end_count #(.P_SAMPLE_DIV(4)) uut (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_remote_in(remote),
        .i_leader_detect(leader), .i_low_width_detect(low_w),
        .o_rx_complete(done), .o_irq(irq));
    irr_remote_model #(.P_HALF(8)) model (.i_mclk(i_mclk),
        .o_remote(remote), .o_leader(leader), .o_low_width(low_w));

    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        if (done === 1'b1) done_cnt <= done_cnt + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic int rnd(input int m);
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12]
                  ^ lfsr_q[10]};
        return lfsr_q % m;
    endfunction : rnd
    // only flags and count are compared; count saturates at all ones
    function automatic logic [31:0] exp_stat(input logic [3:0] f, int c);
        return {16'h0, f, 5'h0, (c > 127) ? 7'h7f : 7'(c)};
    endfunction : exp_stat
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge i_mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge i_mclk);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic frame(input int bits, input bit by_low, input bit exp);
        int start;
        start = done_cnt;
        model.pulse(1'b1);
        model.send_bits(bits);
        if (by_low) model.pulse(1'b0);
        for (int k = 0; k < 80 && done_cnt == start; k++) @(posedge i_mclk);
        check(32'(done_cnt - start), 32'(exp));
    endtask : frame
    task automatic give_verdict();
        if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        i_reset = 1'b1;
        cyc     = 1'b0;
        stb     = 1'b0;
        we      = 1'b0;
        adr     = 8'h00;
        sel     = 4'hf;
        wdat    = 32'h0000_0000;
        repeat (16) @(posedge i_mclk);
        i_reset <= 1'b0;
        foreach (addrs[i]) begin
            wb(1'b0, addrs[i], 32'h0, q);
            check(q, 32'h0);
        end
        for (int i = 1; i < 4; i++) begin
            n = rnd(73);
            wb(1'b1, 8'(4 * i), {25'h1ffffff, 7'(n)}, q);
            wb(1'b0, 8'(4 * i), 32'h0, q);
            check(q, 32'(n));
            wb(1'b1, 8'(4 * i), 32'h0, q);
        end
        sel <= 4'he;
        wb(1'b1, OFS_END_A, 32'h7f, q);
        sel <= 4'hf;
        wb(1'b0, OFS_END_A, 32'h0, q);
        check(q, 32'h0);
        wb(1'b1, OFS_RX_STATUS, 32'hffffffff, q);
        wb(1'b0, OFS_RX_STATUS, 32'h0, q);
        check(q, 32'h0);
        wb(1'b1, OFS_CONTROL, 32'hb, q);
        wb(1'b1, OFS_MAX_CYCLE, 32'h8, q);
        wb(1'b1, OFS_IRQ_MASK, 32'hf000, q);
        model.pulse(1'b1);
        wb(1'b0, OFS_RX_STATUS, 32'h0, q);
        check(q & 32'hf080, 32'h8080);
        check({31'h0, irq}, 32'h1);
        wb(1'b1, OFS_IRQ_STATUS, 32'hf000, q);
        check({31'h0, irq}, 32'h0);
        model.send_bits(1);
        wb(1'b0, OFS_RX_STATUS, 32'h0, q);
        check(q & 32'hf07f, exp_stat(4'h1, 0));
        n = 2 + rnd(9);
        frame(n, 1'b0, 1'b1);
        wb(1'b0, OFS_RX_STATUS, 32'h0, q);
        check(q & 32'hf07f, exp_stat(4'h2, n));
        frame(3, 1'b1, 1'b1);
        wb(1'b0, OFS_RX_STATUS, 32'h0, q);
        check(q & 32'hf07f, exp_stat(4'h4, 3));
        wb(1'b1, OFS_IRQ_MASK, 32'h0, q);
        check({31'h0, irq}, 32'h0);
        wb(1'b1, OFS_IRQ_MASK, 32'hf000, q);
        check({31'h0, irq}, 32'h1);
        frame(4, 1'b0, 1'b1);
        frame(75, 1'b0, 1'b1);
        wb(1'b0, OFS_RX_STATUS, 32'h0, q);
        check(q & 32'hf07f, exp_stat(4'h2, 75));
        wb(1'b1, OFS_CONTROL, 32'h1, q);
        wb(1'b1, OFS_END_A, 32'h3, q);
        wb(1'b1, OFS_END_B, 32'h5, q);
        wb(1'b1, OFS_END_C, 32'h9, q);
        last = 75;
        foreach (ns[i]) begin
            frame(ns[i], 1'b0, ns[i] inside {3, 5, 9});
            if (ns[i] inside {3, 5, 9}) last = ns[i];
            wb(1'b0, OFS_RX_STATUS, 32'h0, q);
            check(q & 32'hf07f, exp_stat(4'h2, last));
        end
        frame(4, 1'b1, 1'b1);
        wb(1'b0, OFS_RX_STATUS, 32'h0, q);
        check(q & 32'hf07f, exp_stat(4'h4, 4));
        give_verdict();
    end
endmodule : irr_status_end_count_tb_top

//--- tb/irr_status_properties.sv
// checker of bus answers and status read-back of the remote receiver block
`timescale 1ns/1ps
module irr_status_properties
    import irr_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_reset,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic        i_leader_detect,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_rx_complete,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);
    logic take;
    logic rd_stat;
    logic rd_end;
    assign take    = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign rd_stat = take && !i_wb_we && i_wb_adr == OFS_RX_STATUS;
    assign rd_end  = take && !i_wb_we && (i_wb_adr == OFS_END_A ||
                     i_wb_adr == OFS_END_B || i_wb_adr == OFS_END_C);
    // ****************************************************************
    // assertions
    // ****************************************************************
    a_ack_after_take:
        assert property (take |=> o_wb_ack)
        else $error("bus request not answered next cycle");
    a_ack_one_cycle:
        assert property (o_wb_ack |=> !o_wb_ack)
        else $error("acknowledge held longer than one cycle");
    a_no_idle_ack:
        assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
        else $error("acknowledge without a request");
    a_unmapped_zero:
        assert property (take && !i_wb_we && i_wb_adr >= 8'h20
                         |=> o_wb_dat == 32'h0)
        else $error("unmapped address read nonzero");
    a_status_spare_zero:
        assert property (rd_stat |=> o_wb_dat[31:16] == 16'h0
                         && o_wb_dat[11:8] == 4'h0)
        else $error("spare status bits read nonzero");
    a_flag_one_cause:
        assert property (rd_stat |=> $onehot0(o_wb_dat[15:12]))
        else $error("more than one event flag in status");
    a_end_field_width:
        assert property (rd_end |=> o_wb_dat[31:7] == 25'h0)
        else $error("end count read beyond seven bits");
    a_leader_no_end:
        assert property (i_leader_detect |=> !o_rx_complete)
        else $error("completion reported right after a leader");
    a_complete_pulse:
        assert property (o_rx_complete |=> !o_rx_complete)
        else $error("completion pulse longer than one cycle");
    c_complete: cover property (o_rx_complete);
    c_irq_high: cover property ($rose(o_irq));
    c_status_read: cover property (rd_stat);
endmodule : irr_status_properties

bind irr_status_end_count irr_status_properties u_props (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_leader_detect(i_leader_detect), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .o_rx_complete(o_rx_complete), .o_irq(o_irq)
);
